// ==== design/afw_pkg.sv ====
// Package for the automatic adjustment window controller: register map, layouts, reset values.
package afw_pkg;

	// Register byte offsets on the AHB-Lite slave.
	localparam logic [7:0] REG_MODE      = 8'h00;
	localparam logic [7:0] REG_WIN_SEL   = 8'h04;
	localparam logic [7:0] REG_STAT_X    = 8'h08;
	localparam logic [7:0] REG_STAT_W    = 8'h0C;
	localparam logic [7:0] REG_STAT_Y    = 8'h10;
	localparam logic [7:0] REG_STAT_H    = 8'h14;
	localparam logic [7:0] REG_IMG_X     = 8'h18;
	localparam logic [7:0] REG_IMG_W     = 8'h1C;
	localparam logic [7:0] REG_IMG_Y     = 8'h20;
	localparam logic [7:0] REG_IMG_H     = 8'h24;
	localparam logic [7:0] REG_TARGET    = 8'h28;
	localparam logic [7:0] REG_LIMITS    = 8'h2C;
	localparam logic [7:0] REG_PARAM     = 8'h30;
	localparam logic [7:0] REG_STATUS    = 8'h34;

	// Coordinate width and sensor size that the reset window covers.
	localparam int           COORD_W     = 12;
	localparam logic [11:0]  SENSOR_W    = 12'h293;
	localparam logic [11:0]  SENSOR_H    = 12'h1EE;

	// Adjustment mode encodings held in the mode register.
	localparam logic [1:0]   MODE_OFF    = 2'h0;
	localparam logic [1:0]   MODE_ONCE   = 2'h1;
	localparam logic [1:0]   MODE_CONT   = 2'h2;

	// Selector code of the first statistics window, the only one implemented.
	localparam logic [1:0]   SEL_FIRST   = 2'h0;

	// Single-shot give-up count in frames and the accepted error band.
	localparam logic [4:0]   ONCE_MAX_FRAMES = 5'h1E;
	localparam logic [7:0]   TOLERANCE       = 8'h02;

	// Reset values of target, limits and controlled parameter.
	localparam logic [7:0]   RST_TARGET  = 8'h80;
	localparam logic [15:0]  RST_LOWER   = 16'h0000;
	localparam logic [15:0]  RST_UPPER   = 16'hFFFF;
	localparam logic [15:0]  RST_PARAM   = 16'h0100;

	// Field positions inside the limits and status words.
	localparam int           LIM_UPPER_LSB  = 16;
	localparam int           STS_AVG_LSB    = 0;
	localparam int           STS_TRIES_LSB  = 8;
	localparam int           STS_NOOVL_BIT  = 16;
	localparam int           STS_BUSY_BIT   = 17;

	// A rectangle: offset and size in each direction.
	typedef struct packed {
		logic [11:0] x;
		logic [11:0] w;
		logic [11:0] y;
		logic [11:0] h;
	} afw_win_t;

	// One beat from the pixel pipeline, already binned where binning is on.
	typedef struct packed {
		logic       sof;
		logic       valid;
		logic       eol;
		logic       eof;
		logic [7:0] data;
	} afw_pix_t;

endpackage : afw_pkg

// ==== design/afw_ctrl.sv ====
// Automatic adjustment controller: statistics window, frame average and off/once/continuous loop.
//
// Behaviour
// RQ1: Once mode adjusts until target, then off.
// RQ2: Once mode gives up after 30 frames.
// RQ3: Continuous mode adjusts per frame when free.
// RQ4: Continuous runs until once or off.
// RQ5: Later once, continuous or manual writes accepted.
// RQ6: Settings accepted live; take effect later.
// RQ7: Coordinates start at column 0, row 0.
// RQ8: Window is offset, width, offset, height.
// RQ9: Only statistics and image window overlap counts.
// RQ10: No overlap means no adjustment.
// RQ11: Reset window covers full sensor.
// RQ12: Software keeps window within sensor bounds.
// RQ13: Offsets and sizes in 1 pixel steps.
// RQ14: Software may prefer even steps on colour.
// RQ15: Binned pixels give virtual coordinates.
// RQ16: Software selects window before setting it.
// RQ17: Software configures fully, then enables.
// RQ18: Automatic result overwrites manual value; a manual write in the same cycle wins over it.
// RQ19: Target spans 0 to 255 always.
// RQ20: Frame average delivered at frame end.
`timescale 1ns/1ns
`default_nettype none

module afw_ctrl
	import afw_pkg::*;
(
	// Clock and reset.
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave.
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// Pixel pipeline.
	input  wire afw_pix_t    pix,
	// Controlled parameter towards the image pipeline.
	output logic [15:0]      param_value,
	output logic             param_update
);

	// Adjustment engine states.
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b001,
		ST_DIVIDE = 3'b010,
		ST_ADJUST = 3'b100
	} afw_state_t;

	afw_state_t  state;          // Engine state.
	logic [1:0]  mode;           // Off, once or continuous.
	logic [1:0]  win_sel;        // Statistics window selector.
	afw_win_t    stat_win;       // Programmed statistics window.
	afw_win_t    img_win;        // Programmed output image window.
	afw_win_t    stat_act;       // Statistics window latched at frame start.
	afw_win_t    img_act;        // Image window latched at frame start.
	logic [7:0]  target;         // Target average gray level.
	logic [15:0] lim_lower;      // Lower limit of the parameter.
	logic [15:0] lim_upper;      // Upper limit of the parameter.
	logic [4:0]  tries;          // Frames used by the current once run.
	logic [11:0] col;            // Column of the next pixel.
	logic [11:0] row;            // Row of the current line.
	logic [31:0] sum;            // Gray level sum over counted pixels.
	logic [23:0] cnt;            // Number of counted pixels.
	logic [31:0] rem;            // Divider remainder.
	logic [23:0] div_cnt;        // Divisor held during division.
	logic [2:0]  bitpos;         // Quotient bit being resolved.
	logic [7:0]  avg;            // Last frame average.
	logic        no_overlap;     // Last frame had no counted pixel.
	logic        adj_done_once;  // Once run finishes this cycle.
	logic        ph_write;       // Data phase of a write pending.
	logic [7:0]  ph_addr;        // Address held for that write.
	logic [31:0] rd_word;        // Read data chosen in the address phase.
	logic        addr_ok;        // Address phase accepted this cycle.
	logic        in_stat;        // Pixel inside the statistics window.
	logic        in_img;         // Pixel inside the image window.
	logic [31:0] div_sub;        // Shifted divisor for this step.
	logic signed [17:0] next_raw;   // Parameter before clamping.
	logic [15:0] next_param;     // Clamped parameter.
	logic [7:0]  abs_err;        // Distance of average from target.

	// True when coordinate c lies in [off, off+size); the sum is widened to avoid wrap.
	// The name avoids the reserved set-membership operator of the language.
	function automatic logic in_span(input logic [11:0] c, input logic [11:0] off,
			input logic [11:0] size);
		logic [12:0] lim;
		lim = {1'b0, off} + {1'b0, size};
		in_span = (c >= off) && ({1'b0, c} < lim);
	endfunction : in_span

	// The slave never inserts wait states and always answers OKAY.
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign addr_ok   = hsel && htrans[1] && hready;

	// Address phase capture; a write completes in the following data phase.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_write <= 1'b0;
			ph_addr  <= 8'h00;
		end else begin
			ph_write <= addr_ok && hwrite;
			ph_addr  <= haddr[7:0];
		end
	end

	// Read multiplexer; unmapped addresses read as zero.
	always_comb begin
		rd_word = 32'h0000_0000;
		case (haddr[7:0])
			REG_MODE:    rd_word = {30'h0, mode};
			REG_WIN_SEL: rd_word = {30'h0, win_sel};
			REG_STAT_X:  rd_word = {20'h0, stat_win.x};
			REG_STAT_W:  rd_word = {20'h0, stat_win.w};
			REG_STAT_Y:  rd_word = {20'h0, stat_win.y};
			REG_STAT_H:  rd_word = {20'h0, stat_win.h};
			REG_IMG_X:   rd_word = {20'h0, img_win.x};
			REG_IMG_W:   rd_word = {20'h0, img_win.w};
			REG_IMG_Y:   rd_word = {20'h0, img_win.y};
			REG_IMG_H:   rd_word = {20'h0, img_win.h};
			REG_TARGET:  rd_word = {24'h0, target};
			REG_LIMITS:  rd_word = {lim_upper, lim_lower};
			REG_PARAM:   rd_word = {16'h0, param_value};
			REG_STATUS: begin
				rd_word[STS_AVG_LSB +: 8]   = avg;
				rd_word[STS_TRIES_LSB +: 5] = tries;
				rd_word[STS_NOOVL_BIT]      = no_overlap;
				rd_word[STS_BUSY_BIT]       = (state != ST_IDLE);
			end
			default:     rd_word = 32'h0000_0000;
		endcase
	end

	// Read data is registered so it stands through the whole data phase.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (addr_ok && !hwrite) begin
			hrdata <= rd_word;
		end
	end

	// Configuration registers; live writes are fine because the pixel path uses copies.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			win_sel   <= SEL_FIRST;
			// RQ11 full sensor window
			stat_win  <= '{x: 12'h000, w: SENSOR_W, y: 12'h000, h: SENSOR_H};
			img_win   <= '{x: 12'h000, w: SENSOR_W, y: 12'h000, h: SENSOR_H};
			target    <= RST_TARGET;
			lim_lower <= RST_LOWER;
			lim_upper <= RST_UPPER;
		end else if (ph_write) begin
			// RQ13 single pixel steps
			case (ph_addr)
				REG_WIN_SEL: win_sel <= hwdata[1:0];
				REG_IMG_X:   img_win.x <= hwdata[11:0];
				REG_IMG_W:   img_win.w <= hwdata[11:0];
				REG_IMG_Y:   img_win.y <= hwdata[11:0];
				REG_IMG_H:   img_win.h <= hwdata[11:0];
				// RQ19 full 8-bit target
				REG_TARGET:  target <= hwdata[7:0];
				REG_LIMITS: begin
					lim_lower <= hwdata[15:0];
					lim_upper <= hwdata[LIM_UPPER_LSB +: 16];
				end
				default: begin
					// RQ8 window fields, only through the first selector
					if (win_sel == SEL_FIRST) begin
						if (ph_addr == REG_STAT_X) stat_win.x <= hwdata[11:0];
						if (ph_addr == REG_STAT_W) stat_win.w <= hwdata[11:0];
						if (ph_addr == REG_STAT_Y) stat_win.y <= hwdata[11:0];
						if (ph_addr == REG_STAT_H) stat_win.h <= hwdata[11:0];
					end
				end
			endcase
		end
	end

	// Mode register; a software write outranks the engine turning itself off.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode <= MODE_OFF;
		end else if (ph_write && ph_addr == REG_MODE) begin
			mode <= hwdata[1:0];
		end else if (adj_done_once) begin
			// RQ1 once returns off
			mode <= MODE_OFF;
		end
	end

	// RQ7 origin at zero
	// Pixel position tracking; binned beats count as virtual columns and lines.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			col      <= 12'h000;
			row      <= 12'h000;
			stat_act <= '0;
			img_act  <= '0;
		end else if (pix.sof) begin
			// RQ6 window settings apply at frame start
			col      <= 12'h000;
			row      <= 12'h000;
			stat_act <= stat_win;
			img_act  <= img_win;
		end else if (pix.eol) begin
			// RQ15 virtual line advance
			col <= 12'h000;
			row <= row + 12'h001;
		end else if (pix.valid) begin
			col <= col + 12'h001;
		end
	end

	// RQ9 overlap test
	assign in_stat = in_span(col, stat_act.x, stat_act.w) && in_span(row, stat_act.y, stat_act.h);
	assign in_img  = in_span(col, img_act.x, img_act.w) && in_span(row, img_act.y, img_act.h);

	// Statistics accumulation over the overlap of the two windows.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sum <= 32'h0000_0000;
			cnt <= 24'h00_0000;
		end else if (pix.sof) begin
			sum <= 32'h0000_0000;
			cnt <= 24'h00_0000;
		end else if (pix.valid && !pix.eol && in_stat && in_img) begin
			sum <= sum + {24'h00_0000, pix.data};
			cnt <= cnt + 24'h00_0001;
		end
	end

	// Divider and clamp arithmetic for the adjustment step.
	always_comb begin
		div_sub  = {8'h00, div_cnt} << bitpos;
		next_raw = $signed({2'b00, param_value}) + $signed({10'h000, target})
			- $signed({10'h000, avg});
		if (next_raw < $signed({2'b00, lim_lower})) begin
			next_param = lim_lower;
		end else if (next_raw > $signed({2'b00, lim_upper})) begin
			next_param = lim_upper;
		end else begin
			next_param = next_raw[15:0];
		end
		abs_err = (avg > target) ? (avg - target) : (target - avg);
	end

	// A once run ends when the average is close enough or the frame budget is spent.
	// RQ2 thirty frame limit
	// An empty overlap never counts as on target, so such a run ends only on the budget.
	assign adj_done_once = (state == ST_ADJUST) && (mode == MODE_ONCE)
		&& ((!no_overlap && (abs_err <= TOLERANCE)) || (tries >= ONCE_MAX_FRAMES - 5'h01));

	// Engine: takes a frame at its end, divides, then steps the parameter.
	// A frame that ends while the engine is busy is dropped, which lowers the rate.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state      <= ST_IDLE;
			rem        <= 32'h0000_0000;
			div_cnt    <= 24'h00_0000;
			bitpos     <= 3'h7;
			avg        <= 8'h00;
			no_overlap <= 1'b0;
		end else begin
			case (state)
				ST_IDLE: begin
					// RQ3 adjust each free frame
					if (pix.eof && mode != MODE_OFF) begin
						rem        <= sum;
						div_cnt    <= cnt;
						bitpos     <= 3'h7;
						avg        <= 8'h00;
						// RQ10 empty overlap flagged
						no_overlap <= (cnt == 24'h00_0000);
						state      <= ST_DIVIDE;
					end
				end
				ST_DIVIDE: begin
					// RQ20 average by shift-subtract
					if (!no_overlap && rem >= div_sub) begin
						rem         <= rem - div_sub;
						avg[bitpos] <= 1'b1;
					end
					bitpos <= bitpos - 3'h1;
					if (bitpos == 3'h0) begin
						state <= ST_ADJUST;
					end
				end
				ST_ADJUST: begin
					state <= ST_IDLE;
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// Frames spent by a once run; cleared whenever once is not active.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tries <= 5'h00;
		end else if (mode != MODE_ONCE || adj_done_once) begin
			tries <= 5'h00;
		end else if (state == ST_ADJUST) begin
			tries <= tries + 5'h01;
		end
	end

	// Controlled parameter; a manual write wins over an automatic step in the same cycle.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			param_value  <= RST_PARAM;
			param_update <= 1'b0;
		end else if (ph_write && ph_addr == REG_PARAM) begin
			// RQ5 manual write accepted
			param_value  <= hwdata[15:0];
			param_update <= 1'b1;
		end else if (state == ST_ADJUST && mode != MODE_OFF && !no_overlap) begin
			// RQ18 overwrite manual value
			// RQ4 value kept after off
			param_value  <= next_param;
			param_update <= 1'b1;
		end else begin
			param_update <= 1'b0;
		end
	end

endmodule : afw_ctrl

`default_nettype wire

// ==== verif/afw_ctrl_checker.sv ====
// Port checker for the adjustment window controller.
`timescale 1ns/1ns
`default_nettype none
module afw_ctrl_checker
	import afw_pkg::*;
(
	// Clock and reset.
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// Bus side.
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic        hready,
	input  wire logic        hreadyout,
	input  wire logic        hresp,
	input  wire logic [31:0] hrdata,
	// Pixel and parameter side.
	input  wire afw_pix_t    pix,
	input  wire logic [15:0] param_value,
	input  wire logic        param_update
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic take;    // An address phase is accepted this cycle.
	logic man_wr;  // A manual parameter write is in its data phase.
	logic rd_take; // A read address phase is accepted this cycle.
	assign take = hsel && htrans[1] && hready;
	assign rd_take = take && !hwrite;
	// Manual writes are the only parameter change besides the engine, so track them.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			man_wr <= 1'b0;
		end else begin
			man_wr <= take && hwrite && (haddr[7:0] == REG_PARAM);
		end
	end
	a_ready_high: assert property (hreadyout) else $error("wait state inserted");
	a_resp_okay: assert property (!hresp) else $error("error response");
	a_update_pulse: assert property (param_update |=> !param_update) else $error("long update");
	a_value_cause: assert property ($changed(param_value) |-> param_update || $past(man_wr))
		else $error("parameter changed without cause");
	a_engine_lag: assert property (param_update && !$past(man_wr) |-> $past(pix.eof, 10))
		else $error("update not ten cycles after frame end");
	a_unmapped_zero: assert property (rd_take && haddr[7:0] > REG_STATUS |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	a_status_spare: assert property (rd_take && haddr[7:0] == REG_STATUS |=>
		hrdata[31:18] == 14'h0 && hrdata[15:13] == 3'h0) else $error("status spare bits set");
	a_mode_width: assert property (rd_take && haddr[7:0] == REG_MODE |=> hrdata[31:2] == 30'h0)
		else $error("mode spare bits set");
	// Main scenarios: engine result, manual write, frame end.
	c_engine: cover property (param_update && !$past(man_wr));
	c_manual: cover property (man_wr);
	c_frame: cover property (pix.eof);
endmodule : afw_ctrl_checker
`default_nettype wire

// ==== verif/afw_pix_src.sv ====
// Pixel pipeline model: small frames whose left and right halves differ in level.
`timescale 1ns/1ns
`default_nettype none
module afw_pix_src
	import afw_pkg::*;
#(
	parameter int COLS  = 16,
	parameter int ROWS  = 4,
	parameter int SPLIT = 8
)
(
	// Pipeline clock.
	input  wire logic    hclk,
	// Beats towards the controller.
	output var afw_pix_t pix
);
	initial begin
		pix = '0;
	end
	// One beat; data toggles when no pixel rides, so stale values are never mistaken for data.
	task automatic beat(input logic s, input logic v, input logic l, input logic e,
		input logic [7:0] d);
		pix <= '{sof: s, valid: v, eol: l, eof: e, data: (v ? d : ~pix.data)};
		@(posedge hclk);
	endtask : beat
	// Start marker, lines closed by a line marker, end marker, then a gap over ten cycles.
	task automatic send_frame(input logic [7:0] lo, input logic [7:0] hi);
		int r;
		int c;
		beat(1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
		for (r = 0; r < ROWS; r++) begin
			for (c = 0; c < COLS; c++) begin
				beat(1'b0, 1'b1, 1'b0, 1'b0, (c < SPLIT) ? lo : hi);
			end
			beat(1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
		end
		beat(1'b0, 1'b0, 1'b0, 1'b1, 8'h00);
		repeat (14) beat(1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
	endtask : send_frame
endmodule : afw_pix_src
`default_nettype wire

// ==== verif/afw_ctrl_bench.sv ====
// Bench for the adjustment window controller: bus tasks, frames and expected results.
`timescale 1ns/1ns
`default_nettype none
module afw_ctrl_bench import afw_pkg::*;;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, param_update;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [15:0] param_value;
	afw_pix_t    pix;
	int          fails, n_checks, i;
	int          cyc = 0;
	// Reset map: addresses and expected values, the last one unmapped.
	localparam logic [7:0] RA [14] = '{REG_MODE, REG_WIN_SEL, REG_STAT_X, REG_STAT_W, REG_STAT_Y,
		REG_STAT_H, REG_IMG_X, REG_IMG_W, REG_IMG_Y, REG_IMG_H, REG_TARGET, REG_LIMITS, REG_PARAM, 8'h3C};
	localparam logic [31:0] RV [14] = '{32'h0, 32'h0, 32'h0, 32'h293, 32'h0, 32'h1EE, 32'h0,
		32'h293, 32'h0, 32'h1EE, 32'h80, 32'hFFFF0000, 32'h100, 32'h0};
	afw_ctrl afw_ctrl_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pix(pix),
		.param_value(param_value), .param_update(param_update));
	afw_pix_src afw_pix_src_i (.hclk(hclk), .pix(pix));
	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end
	// A hang counts as a mismatch; the whole run needs under ten thousand cycles.
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 10000) begin
			fails++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : report_and_stop
	// One word transfer; the address phase is held until hready, then the data phase.
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= wr;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : xfer
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk(nm, exp, rd);
	endtask : rchk
	task automatic frame();
		afw_pix_src_i.send_frame(8'h40, 8'hC0);
	endtask : frame
	initial begin
		{hresetn, hsel, hwrite, htrans, haddr, hwdata, fails, n_checks} = '0;
		hsize = 3'h2;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (i = 0; i < 14; i++) rchk("reset map", RA[i], RV[i]);
		// Window at columns 5..7 from odd offset 5, rows 1..2, inside the sensor; left half level 40.
		xfer(1'b1, REG_WIN_SEL, {30'h0, SEL_FIRST});
		xfer(1'b1, REG_STAT_X, 32'h5);
		xfer(1'b1, REG_STAT_W, 32'h3);
		xfer(1'b1, REG_STAT_Y, 32'h1);
		xfer(1'b1, REG_STAT_H, 32'h2);
		xfer(1'b1, REG_MODE, {30'h0, MODE_CONT});
		frame();
		rchk("status", REG_STATUS, 32'h40);
		chk("param", 32'h140, {16'h0, param_value});
		frame();
		chk("param", 32'h180, {16'h0, param_value});
		// Another selector must not move the first window.
		xfer(1'b1, REG_WIN_SEL, 32'h1);
		xfer(1'b1, REG_STAT_X, 32'hA);
		xfer(1'b1, REG_WIN_SEL, 32'h0);
		rchk("stat x", REG_STAT_X, 32'h5);
		// Image window at columns 12..15 leaves no overlap.
		xfer(1'b1, REG_IMG_X, 32'hC);
		xfer(1'b1, REG_IMG_W, 32'h4);
		frame();
		chk("param", 32'h180, {16'h0, param_value});
		xfer(1'b0, REG_STATUS, 32'h0);
		chk("no overlap", 32'h1, {31'h0, rd[16]});
		xfer(1'b1, REG_IMG_X, 32'h0);
		xfer(1'b1, REG_IMG_W, 32'h293);
		xfer(1'b1, REG_MODE, {30'h0, MODE_OFF});
		frame();
		chk("param", 32'h180, {16'h0, param_value});
		// Once mode already on target stops after one frame.
		xfer(1'b1, REG_TARGET, 32'h40);
		xfer(1'b1, REG_MODE, {30'h0, MODE_ONCE});
		frame();
		rchk("mode", REG_MODE, 32'h0);
		// Limits pinned at 200 keep the target out of reach.
		xfer(1'b1, REG_TARGET, 32'hC0);
		xfer(1'b1, REG_LIMITS, 32'h02000200);
		xfer(1'b1, REG_MODE, {30'h0, MODE_ONCE});
		repeat (29) frame();
		rchk("mode", REG_MODE, {30'h0, MODE_ONCE});
		rchk("status", REG_STATUS, 32'h00001D40);
		frame();
		rchk("mode", REG_MODE, 32'h0);
		chk("param", 32'h200, {16'h0, param_value});
		// Manual value then continuous mode builds on it.
		xfer(1'b1, REG_LIMITS, 32'hFFFF0000);
		xfer(1'b1, REG_PARAM, 32'h123);
		rchk("param reg", REG_PARAM, 32'h123);
		xfer(1'b1, REG_MODE, {30'h0, MODE_CONT});
		frame();
		chk("param", 32'h1A3, {16'h0, param_value});
		xfer(1'b1, REG_TARGET, 32'hFF);
		rchk("target", REG_TARGET, 32'hFF);
		xfer(1'b1, REG_TARGET, 32'h0);
		rchk("target", REG_TARGET, 32'h0);
		report_and_stop();
	end
endmodule : afw_ctrl_bench
bind afw_ctrl afw_ctrl_checker afw_ctrl_checker_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
	.hresp(hresp), .hrdata(hrdata), .pix(pix), .param_value(param_value),
	.param_update(param_update));
`default_nettype wire
